/* File: rtl/servo_host_regs.svh */
`ifndef SERVO_HOST_REGS_SVH
`define SERVO_HOST_REGS_SVH
// clock and link timing, times in ns as specified
`define CLK_NS 4
`define T_HIGH_MIN_NS 800
`define T_LOW_BASE_NS 600
`define T_CAL_SETUP_NS 20000
`define HIGH_MIN_CYC ((`T_HIGH_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define LOW_BASE_CYC ((`T_LOW_BASE_NS + `CLK_NS - 1) / `CLK_NS)
`define CAL_SETUP_CYC ((`T_CAL_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYC 16'h0006
// own register byte offsets
`define OFS_CFG 8'h00
`define OFS_CMD 8'h04
`define OFS_GATE 8'h08
`define OFS_DACA 8'h0c
`define OFS_DACB 8'h10
`define OFS_STAT 8'h14
`define OFS_RES0 8'h18
`define OFS_RES3 8'h24
// device control word fields and values, own command register bits
`define CF_BC_LO 4
`define CF_FMT 6
`define CF_CAL 7
`define CF_MLO 8
`define CF_MHI 9
`define CFG_RST 10'h364
`define SR_WR_WORD 10'h3e0
`define CMD_RUN 0
`define CMD_SRW 1
// device port addresses
`define PA_DACA 2'h0
`define PA_DACB 2'h1
`define PA_CR 2'h2
`define PA_STACK 2'h3
`endif

/* File: rtl/servo_host_pkg.sv */
package servo_host_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_WR, ST_SETUP, ST_HIGH, ST_LOW, ST_RD} seq_state_type;
  typedef struct packed {
    logic gate;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] addr;
    logic [9:0] db_o;
    logic db_oe;
  } dev_pins_type;
  typedef struct packed {
    seq_state_type st;
    logic [15:0] cnt;
    logic [2:0] pulses;
    logic [2:0] rd_idx;
    dev_pins_type pins;
    logic [9:0] cfg;
    logic [11:0] gate_high;
    logic [9:0] dac_a;
    logic [7:0] dac_b;
    logic [9:0] dev_status;
    logic [3:0][9:0] result;
    logic [9:0] db_s1;
    logic [9:0] db_s2;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } host_state_type;
endpackage

/* File: rtl/servo_host.sv */
// Contract
// R1: device resets integrator when gate falls
// R2: full cycle count gives good flag
// R3: short burst stops at fall, flagged bad
// R4: no zero crossings: nothing integrated, bad
// R5: bad burst still converted and stored
// R6: write pointer steers bursts to channels
// R7: one gate pulse per burst, then convert
// R8: results fill result registers in order
// R9: after conversion, all back to track
// R10: multiplexer enabled for sequence only
// R11: gated mode: zero count, cal low, modes high
// R12: gated mode integrates while gate high
// R13: gated gate high at least 800 ns
// R14: gated hold delayed at most 600 ns
// R15: gate low 0.6 us plus 0.375 high
// R16: gated mode quality flags are ignored
// R17: cal mode: modes 10 and cal bit high
// R18: cal mode: nth fall holds channel n
// R19: cal pulses equal programmed burst count
// R20: cal pulses 800 ns, 20 us setup first; code makes cal pulses the programmed gate high time, at least 800 ns
// R21: format bit selects DAC coding
// R22: reset sets format bit, DACs mid-scale
// R23: busy from first gate to conversions done
// R24: sync mode holds one cycle after count
// R25: burst count field encodes one to four
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`include "servo_host_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module servo_host #(
  parameter int unsigned CAL_SETUP_CYC = `CAL_SETUP_CYC
) (
  input wire logic hclk, // 250 MHz bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data, registered
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  output servo_host_pkg::dev_pins_type dev_pins, // device pins, registered
  input wire logic [9:0] db_i // device data bus, asynchronous
);
  servo_host_pkg::host_state_type s_r;
  servo_host_pkg::host_state_type s_nxt;
  logic [2:0] nb;
  logic [15:0] low_cyc;
  logic [17:0] low_x3;
  logic [9:0] val;
  logic [1:0] ridx;

  function automatic logic cal_mode(input logic [9:0] c);
    cal_mode = c[`CF_MHI] & ~c[`CF_MLO];
  endfunction

  function automatic logic gated_mode(input logic [9:0] c);
    gated_mode = (c[3:0] == 4'h0) & ~c[`CF_CAL] & c[`CF_MHI] & c[`CF_MLO];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // derived counts
  assign nb = {1'b0, s_r.cfg[`CF_BC_LO+1:`CF_BC_LO]} + 3'h1; // R25
  // low time grows with the preceding high time, rounded up
  assign low_x3 = 18'({6'h00, s_r.gate_high} * 18'h00003) + 18'h00007;
  assign low_cyc = 16'(`LOW_BASE_CYC) + 16'(low_x3 >> 3); // R15
  assign val = (gated_mode(s_r.cfg) && s_r.rd_idx == 3'h0) ?
               (s_r.db_s2 & 10'h3e1) : s_r.db_s2; // R16
  assign ridx = 2'(s_r.rd_idx - 3'h1);
  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign dev_pins = s_r.pins;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.db_s1 = db_i;
    s_nxt.db_s2 = s_r.db_s1;
    s_nxt.cnt = s_r.cnt + 16'h0001;
    s_nxt.wr_pend = hsel & hready & htrans[1] & hwrite;
    s_nxt.wr_addr = haddr[7:0];
    // read data is fetched in the address phase so zero wait states hold
    if (hsel && hready && htrans[1] && !hwrite) begin
      s_nxt.rdata = 32'h0000_0000;
      if (haddr[7:0] == `OFS_CFG) begin
        s_nxt.rdata = {22'h000000, s_r.cfg};
      end else if (haddr[7:0] == `OFS_GATE) begin
        s_nxt.rdata = {20'h00000, s_r.gate_high};
      end else if (haddr[7:0] == `OFS_DACA) begin
        s_nxt.rdata = {22'h000000, s_r.dac_a};
      end else if (haddr[7:0] == `OFS_DACB) begin
        s_nxt.rdata = {24'h000000, s_r.dac_b};
      end else if (haddr[7:0] == `OFS_STAT) begin
        s_nxt.rdata = {21'h000000, s_r.dev_status, s_r.st != servo_host_pkg::ST_IDLE};
      end else if (haddr[7:0] >= `OFS_RES0 && haddr[7:0] <= `OFS_RES3 && haddr[1:0] == 2'h0) begin
        s_nxt.rdata = {22'h000000, s_r.result[2'(haddr[7:2] - 6'h06)]};
      end
    end
    unique case (s_r.st)
      servo_host_pkg::ST_IDLE: begin
        s_nxt.cnt = 16'h0000;
        // writes while a job runs are dropped
        if (s_r.wr_pend) begin
          if (s_r.wr_addr == `OFS_GATE) begin
            s_nxt.gate_high = (hwdata[11:0] < 12'(`HIGH_MIN_CYC)) ?
                              12'(`HIGH_MIN_CYC) : hwdata[11:0]; // R13 R20 R24
          end else if (s_r.wr_addr == `OFS_CMD && hwdata[`CMD_RUN]) begin
            s_nxt.pulses = 3'h0;
            if (cal_mode(s_r.cfg)) begin
              s_nxt.st = servo_host_pkg::ST_SETUP; // R20
            end else begin
              s_nxt.st = servo_host_pkg::ST_HIGH;
              // the first rise opens the sequence on the device side
              s_nxt.pins.gate = 1'b1; // R10 R12
            end
          end else if (s_r.wr_addr == `OFS_CFG || s_r.wr_addr == `OFS_DACA ||
                       s_r.wr_addr == `OFS_DACB ||
                       (s_r.wr_addr == `OFS_CMD && hwdata[`CMD_SRW])) begin
            s_nxt.st = servo_host_pkg::ST_WR;
            s_nxt.pins.cs_n = 1'b0;
            s_nxt.pins.wr_n = 1'b0;
            s_nxt.pins.db_oe = 1'b1;
            if (s_r.wr_addr == `OFS_CFG) begin
              s_nxt.cfg = hwdata[9:0];
              // cal mode must also open the integrate switch
              if (cal_mode(hwdata[9:0])) begin
                s_nxt.cfg[`CF_CAL] = 1'b1; // R17
              end
              s_nxt.pins.addr = `PA_CR;
              s_nxt.pins.db_o = s_nxt.cfg; // R11 R21
            end else if (s_r.wr_addr == `OFS_DACA) begin
              s_nxt.dac_a = hwdata[9:0];
              s_nxt.pins.addr = `PA_DACA;
              s_nxt.pins.db_o = hwdata[9:0];
            end else if (s_r.wr_addr == `OFS_DACB) begin
              s_nxt.dac_b = hwdata[7:0];
              s_nxt.pins.addr = `PA_DACB;
              s_nxt.pins.db_o = {2'h0, hwdata[7:0]};
            end else begin
              s_nxt.pins.addr = `PA_STACK;
              s_nxt.pins.db_o = `SR_WR_WORD;
            end
          end
        end
      end
      servo_host_pkg::ST_WR: begin
        // strobe for STROBE_CYC cycles, then hold data STROBE_CYC more before release
        if (s_r.cnt == `STROBE_CYC - 16'h0001) begin
          s_nxt.pins.wr_n = 1'b1;
          s_nxt.pins.cs_n = 1'b1;
        end
        if (s_r.cnt == 16'(2 * `STROBE_CYC) - 16'h0001) begin
          s_nxt.pins.db_oe = 1'b0;
          s_nxt.st = servo_host_pkg::ST_IDLE;
        end
      end
      servo_host_pkg::ST_SETUP: begin
        // reference settles before the first calibration pulse
        if (s_r.cnt == 16'(CAL_SETUP_CYC - 1)) begin
          s_nxt.cnt = 16'h0000;
          s_nxt.st = servo_host_pkg::ST_HIGH;
          s_nxt.pins.gate = 1'b1; // R20
        end
      end
      servo_host_pkg::ST_HIGH: begin
        if (s_r.cnt == {4'h0, s_r.gate_high} - 16'h0001) begin
          s_nxt.cnt = 16'h0000;
          // the falling gate lets the device reset its integrator
          s_nxt.pins.gate = 1'b0; // R1 R3 R12 R14
          s_nxt.pulses = s_r.pulses + 3'h1; // R6 R7 R19
          s_nxt.st = servo_host_pkg::ST_LOW;
        end
      end
      servo_host_pkg::ST_LOW: begin
        if (s_r.cnt == low_cyc - 16'h0001) begin
          s_nxt.cnt = 16'h0000;
          if (s_r.pulses == nb) begin
            // all bursts gated; read the stack, status first
            s_nxt.st = servo_host_pkg::ST_RD; // R16
            s_nxt.rd_idx = 3'h0;
            s_nxt.pins.addr = `PA_STACK;
            s_nxt.pins.cs_n = 1'b0;
            s_nxt.pins.rd_n = 1'b0;
          end else begin
            s_nxt.st = servo_host_pkg::ST_HIGH;
            s_nxt.pins.gate = 1'b1; // R15
          end
        end
      end
      servo_host_pkg::ST_RD: begin
        if (s_r.cnt == `STROBE_CYC - 16'h0001) begin
          s_nxt.pins.rd_n = 1'b1;
          s_nxt.pins.cs_n = 1'b1;
          if (s_r.rd_idx == 3'h0) begin
            s_nxt.dev_status = val; // R2 R4
            // the stack only rotates once the device is no longer busy
            s_nxt.rd_idx = val[0] ? 3'h0 : 3'h1; // R23
          end else begin
            // results land in burst order whatever their flags say
            s_nxt.result[ridx] = s_r.db_s2; // R5 R8 R18
            s_nxt.rd_idx = s_r.rd_idx + 3'h1;
          end
        end
        if (s_r.cnt == 16'(2 * `STROBE_CYC) - 16'h0001) begin
          s_nxt.cnt = 16'h0000;
          if (s_r.rd_idx > nb) begin
            s_nxt.st = servo_host_pkg::ST_IDLE; // R9
            // clear the count so that a smaller burst count written next stays legal
            s_nxt.pulses = 3'h0;
          end else begin
            s_nxt.pins.cs_n = 1'b0;
            s_nxt.pins.rd_n = 1'b0;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.cfg <= `CFG_RST; // R22
      s_r.gate_high <= 12'(`HIGH_MIN_CYC);
      s_r.pins.cs_n <= 1'b1;
      s_r.pins.rd_n <= 1'b1;
      s_r.pins.wr_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the gate waveform, the control word and the status flags
  logic [15:0] hi_len_r;
  logic [15:0] lo_len_r;
  logic [15:0] last_hi_r;

  // measures gate high and low spans for the timing checks only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_len_r <= 16'h0000;
      lo_len_r <= 16'h0000;
      last_hi_r <= 16'h0000;
    end else begin
      hi_len_r <= s_r.pins.gate ? hi_len_r + 16'h0001 : 16'h0000;
      lo_len_r <= s_r.pins.gate ? 16'h0000 : lo_len_r + 16'h0001;
      if (s_r.pins.gate) begin
        last_hi_r <= hi_len_r + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_gate_high_min: // R13
    assert property ($fell(s_r.pins.gate) |-> hi_len_r >= 16'(`HIGH_MIN_CYC))
    else $error("gate high shorter than minimum");
  a_gate_low_min: // R15
    assert property ($rose(s_r.pins.gate) && s_r.pulses != 3'h0 |->
      lo_len_r >= 16'(`LOW_BASE_CYC) + 16'((18'(last_hi_r) * 18'h00003 + 18'h00007) >> 3))
    else $error("gate low shorter than recovery time");
  a_pulse_limit: // R19
    assert property (s_r.pulses <= nb)
    else $error("more gate pulses than bursts");
  // the count steps on the same edge that drops the gate
  a_gate_per_burst: // R7
    assert property ($fell(s_r.pins.gate) |-> s_r.pulses == $past(s_r.pulses) + 3'h1)
    else $error("gate pulse not counted");
  a_cal_setup: // R20
    assert property ($rose(s_r.pins.gate) && s_r.pulses == 3'h0 && cal_mode(s_r.cfg) |->
      $past(s_r.st) == servo_host_pkg::ST_SETUP)
    else $error("calibration pulse without setup wait");
  a_cal_switch: // R17
    assert property (cal_mode(s_r.cfg) |-> s_r.cfg[`CF_CAL])
    else $error("calibration mode with integrate switch enabled");
  a_cfg_on_port: // R11
    assert property ($fell(s_r.pins.wr_n) && s_r.pins.addr == `PA_CR |->
      s_r.pins.db_o == s_r.cfg && s_r.pins.db_oe)
    else $error("control word on port differs from configuration");
  a_gated_flags: // R16
    assert property (s_r.st == servo_host_pkg::ST_RD && s_r.rd_idx == 3'h0 &&
      s_r.cnt == `STROBE_CYC - 16'h0001 && gated_mode(s_r.cfg) |=>
      s_r.dev_status[4:1] == 4'h0)
    else $error("quality flags kept in gated mode");

  c_gated_seq: cover property (gated_mode(s_r.cfg) && $fell(s_r.st == servo_host_pkg::ST_RD));
  c_cal_seq: cover property (s_r.st == servo_host_pkg::ST_SETUP ##1
    s_r.st == servo_host_pkg::ST_HIGH);
  c_busy_poll: cover property (s_r.st == servo_host_pkg::ST_RD && s_r.rd_idx == 3'h0 &&
    s_r.cnt == 16'(2 * `STROBE_CYC) - 16'h0001);
  c_four_bursts: cover property ($rose(s_r.pulses == 3'h4));
endmodule
`default_nettype wire

/* File: verif/servo_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
module servo_dev_model #(
  parameter int CONV_NS = 2000 // conversion time, longer than a gate low time
) (
  input wire logic rst_n, // device reset, active low
  input wire servo_host_pkg::dev_pins_type pins, // strobes and data from host
  input wire logic [3:0] bad_mask, // bursts that come up short
  input wire logic [9:0] res_base, // code of the first conversion
  output logic [9:0] db // data bus toward host
);
  logic [9:0] cfg, sts, last, dac_a, dac_b;
  logic [3:0][9:0] res;
  int cnt, rp;
  ////////////////////////////////////////////////////////////////////////////////
  // port writes land as the strobe falls; a status write marks all bursts bad
  always @(negedge pins.wr_n or negedge rst_n) begin
    if (!rst_n) begin
      cfg = 10'h364;
      sts = 10'h3e0;
      last = 10'h0;
      cnt = 0;
      rp = 9;
    end else if (!pins.cs_n) begin
      case (pins.addr)
        2'h0: dac_a = pins.db_o;
        2'h1: dac_b = pins.db_o;
        2'h2: cfg = pins.db_o;
        default: sts = sts | 10'h01f;
      endcase
    end
  end
  // busy rises with the first gate of a sequence; the stack restarts at the status word
  always @(posedge pins.gate) begin
    if (rst_n && cnt == 0) begin
      sts = 10'h3e1;
      rp = 0;
    end
  end
  // each falling gate holds channel cnt and sets its flag; conversions follow the last
  always @(negedge pins.gate) begin
    if (rst_n) begin
      sts[cnt + 1] = bad_mask[cnt];
      cnt = cnt + 1;
      if (cnt == cfg[5:4] + 1) begin
        #(CONV_NS);
        for (int k = 0; k < cnt; k++) res[k] = res_base + 10'(k);
        sts[0] = 1'b0;
        cnt = 0;
        rp = 0;
      end
    end
  end
  // stack rotates on each rising read strobe and only when not busy
  always @(posedge pins.rd_n) if (rst_n && !sts[0] && rp <= cfg[5:4] + 1) rp = rp + 1;
  // a released bus shows the inverse of its last value so a stale sample cannot pass
  always @(pins or sts or rp or res) begin
    if (!pins.cs_n && !pins.rd_n && pins.addr == 2'h3) begin
      db = (rp == 0 || rp > cfg[5:4] + 1) ? sts : res[rp - 1];
      last = db;
    end else db = ~last;
  end
endmodule
`default_nettype wire

/* File: verif/servo_host_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module servo_host_tb_top;
  logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic rd_ph = 1'b0, gp = 1'b0, wp = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [3:0] bad_mask = 4'h0;
  logic [9:0] res_base = 10'h0, db_i;
  logic [15:0] lf = 16'h0047;
  wire logic hready;
  servo_host_pkg::dev_pins_type pins;
  logic [31:0] exp_q[$], msk_q[$], dev_q[$];
  int n_errors = 0, checks_done = 0, g_cyc = 200, hi = 0, lo = 0, rises = 0;
  servo_host #(.CAL_SETUP_CYC(20)) i_servo_host (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .dev_pins(pins), .db_i(db_i));
  servo_dev_model i_servo_dev_model (.rst_n(hresetn), .pins(pins), .bad_mask(bad_mask),
    .res_base(res_base), .db(db_i));
  always #2 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // zero wait states are promised, but never assumed
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph <= c;
    wait_rdy();
    rv = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0, 1'b1);
  endtask
  // writes are dropped while busy, so every device port write waits for idle
  task automatic poll;
    int k;
    k = 0;
    do begin
      bus(1'b0, 8'h14, 32'h0, 1'b0);
      k++;
    end while (rv[0] !== 1'b0 && k < 3000);
    if (k >= 3000) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic wr_dev(input logic [7:0] a, input logic [31:0] d, input logic [11:0] e);
    dev_q.push_back({20'h0, e});
    bus(1'b1, a, d, 1'b0);
    poll();
  endtask
  task automatic run(input logic [9:0] c, input logic [9:0] dc, input int n, input logic [9:0] w);
    wr_dev(8'h00, {22'h0, c}, {2'h2, dc});
    lf = nx(lf);
    res_base <= lf[9:0];
    rises = 0;
    bus(1'b1, 8'h04, 32'h1, 1'b0);
    rd(8'h14, 32'h1, 32'h1);
    poll();
    check("pulses", n, rises);
    rd(8'h14, {21'h0, w, 1'b0}, 32'h7ff);
    for (int k = 0; k < n; k++) begin
      rd(8'h18 + 8'(4 * k), {22'h0, res_base + 10'(k)}, 32'h3ff);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: reads against the oldest note, port writes, gate high and low widths
  always @(posedge hclk) begin
    if (rd_ph) check("hrdata", exp_q.pop_front(), hrdata & msk_q.pop_front());
    if (!pins.cs_n && !pins.wr_n && wp) begin
      check("port write", dev_q.pop_front(), {20'h0, pins.addr, pins.db_o});
    end
    if (pins.gate && !gp) begin
      if (rises > 0) check("gate low", 150 + (3 * g_cyc + 7) / 8, lo);
      rises++;
      hi = 1;
    end else if (!pins.gate && gp) begin
      check("gate high", g_cyc, hi);
      lo = 1;
    end else if (pins.gate) hi++;
    else lo++;
    gp = pins.gate;
    wp = pins.wr_n;
  end
  // main sequence
  initial begin
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'h364, 32'hffffffff);
    rd(8'h14, 32'h0, 32'hffffffff);
    rd(8'h40, 32'h0, 32'hffffffff);
    bus(1'b1, 8'h08, 32'h10, 1'b0);
    rd(8'h08, 32'hc8, 32'hfff);
    lf = nx(lf);
    wr_dev(8'h0c, {16'h0, lf}, {2'h0, lf[9:0]});
    rd(8'h0c, {22'h0, lf[9:0]}, 32'hffffffff);
    wr_dev(8'h10, {16'h0, lf}, {4'h4, lf[7:0]});
    wr_dev(8'h04, 32'h2, {2'h3, 10'h3e0});
    for (int n = 1; n <= 4; n++) begin
      lf = nx(lf);
      bad_mask <= lf[3:0];
      run({3'b110, lf[4], 2'(n - 1), 4'h4}, {3'b110, lf[4], 2'(n - 1), 4'h4}, n,
        {5'h1f, lf[3:0] & 4'((1 << n) - 1), 1'b0});
    end
    g_cyc = 240;
    bus(1'b1, 8'h08, 32'hf0, 1'b0);
    bad_mask <= 4'hf;
    run(10'h330, 10'h330, 4, 10'h3e0);
    bad_mask <= 4'h5;
    run(10'h264, 10'h2e4, 3, 10'h3ea);
    close_out();
  end
endmodule
`default_nettype wire
